// ==== tmr_pkg.sv ====
package tmr_pkg;
    // register offsets on the byte bus
    localparam logic [3:0] ADDR_CNT_L  = 4'h0;
    localparam logic [3:0] ADDR_CNT_H  = 4'h1;
    localparam logic [3:0] ADDR_CMPA_L = 4'h2;
    localparam logic [3:0] ADDR_CMPA_H = 4'h3;
    localparam logic [3:0] ADDR_CMPB_L = 4'h4;
    localparam logic [3:0] ADDR_CMPB_H = 4'h5;
    localparam logic [3:0] ADDR_CAP_L  = 4'h6;
    localparam logic [3:0] ADDR_CAP_H  = 4'h7;
    localparam logic [3:0] ADDR_CTRL_A = 4'h8;
    localparam logic [3:0] ADDR_CTRL_B = 4'h9;
    localparam logic [3:0] ADDR_FLAG   = 4'hA;
    localparam logic [3:0] ADDR_MASK   = 4'hB;
    localparam logic [3:0] ADDR_POWER  = 4'hC;
    // control field positions
    localparam int CS_LSB    = 0;
    localparam int WGMH_LSB  = 3;
    localparam int CAP_EDGE  = 6;
    localparam int CAP_NC    = 7;
    localparam int WGML_LSB  = 0;
    localparam int CAP_SRC   = 2;
    localparam int FLG_OVF   = 0;
    localparam int FLG_CMPA  = 1;
    localparam int FLG_CMPB  = 2;
    localparam int FLG_CAP   = 3;
    localparam int PWR_TMR   = 0;
    // clock select codes
    localparam logic [2:0] CS_STOP  = 3'h0;
    localparam logic [2:0] CS_DIV1  = 3'h1;
    localparam logic [2:0] CS_DIV8  = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1K = 3'h5;
    localparam logic [2:0] CS_EXTF  = 3'h6;
    localparam logic [2:0] CS_EXTR  = 3'h7;
    // waveform modes
    localparam logic [3:0] WGM_NORMAL  = 4'h0;
    localparam logic [3:0] WGM_CTC_A   = 4'h4;
    localparam logic [3:0] WGM_FAST_CAP = 4'hE;
    localparam logic [3:0] WGM_FAST_A  = 4'hF;
    localparam logic [15:0] CNT_MAX    = 16'hFFFF;
    localparam logic [15:0] CNT_BOTTOM = 16'h0000;
    localparam logic [7:0]  RST_POWER  = 8'h00;
    localparam int NC_SAMPLES = 4;
endpackage : tmr_pkg

// ==== tmr_edge.sv ====
`timescale 1ns/1ps
module tmr_edge (
    // clock and reset
    input  wire logic CLK_I,
    input  wire logic RST_B_I,
    // sampled level and edge choice
    input  wire logic sig_i,
    input  wire logic rise_i,
    // one-cycle edge pulse
    output logic      edge_o
);
    logic prev_q;

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= sig_i;
        end
    end

    assign edge_o = rise_i ? (sig_i & ~prev_q) : (~sig_i & prev_q);
endmodule : tmr_edge

// ==== tmr_core.sv ====
// What this block does
// - power-off bit set disables the timer
// - bottom is counter value zero
// - top is max, compare A, or capture
// - no clock selected means no counting
// - tick from prescaler or external pin
// - compare matches set compare flags
// - matches drive waveform outputs
// - flags visible, mask gates each request
// - capture copies counter on chosen edge
// - optional noise filter on capture path
// - compare A top is double buffered in fast pwm, not in ctc
// - capture as top frees compare A
// - 16-bit registers via two byte accesses
// - one shared high-byte latch
// - low-byte write loads full register
// - low-byte read copies high into latch
// - compare reads bypass the latch
// - control registers plain 8-bit
// - select 0 stops, 1 direct, 2-5 prescaled
// - select 7 rising, 6 falling external edge
// - CPU counter write beats count
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module tmr_core (
    // clock and reset
    input  wire logic       CLK_I,
    input  wire logic       RST_B_I,
    // register port
    input  wire logic [3:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic      [7:0] RDATA_O,
    // pins
    input  wire logic       EXT_COUNT_PIN_I,
    input  wire logic       CAPTURE_PIN_I,
    input  wire logic       COMPARATOR_I,
    output logic            COMPARE_OUTPUT_A_O,
    output logic            COMPARE_OUTPUT_B_O,
    // masked requests
    output logic            IRQ_OVF_O,
    output logic            IRQ_CMPA_O,
    output logic            IRQ_CMPB_O,
    output logic            IRQ_CAP_O
);
    localparam int NCW = tmr_pkg::NC_SAMPLES;

    logic [15:0] timer_count_value_q;
    logic [15:0] compare_value_a_q;
    logic [15:0] compare_value_b_q;
    logic [15:0] cmpa_buf_q;
    logic [15:0] cmpb_buf_q;
    logic [15:0] capture_value_q;
    logic [7:0]  latch_q;
    logic [7:0]  timer_control_a_q;
    logic [7:0]  timer_control_b_q;
    logic [3:0]  timer_flag_register_q;
    logic [3:0]  timer_mask_register_q;
    logic [7:0]  power_reduction_register_q;
    logic [9:0]  presc_q;
    logic [7:0]  rdata_d;
    logic [15:0] top;
    logic [3:0]  waveform_mode_select;
    logic [2:0]  csel;
    logic        enabled;
    logic        timer_tick;
    logic        ext_edge;
    logic        cap_edge;
    logic        at_top;
    logic        match_a;
    logic        match_b;
    logic        pwm_mode;
    logic        wr_cnt;
    logic        cap_raw;
    logic        cap_filt_q;
    logic [NCW-1:0] cap_hist_q;
    logic        cap_sig;
    logic        cap_top;
    logic        tick_q;

    assign waveform_mode_select = {timer_control_b_q[tmr_pkg::WGMH_LSB +: 2],
                                   timer_control_a_q[tmr_pkg::WGML_LSB +: 2]};
    assign csel   = timer_control_b_q[tmr_pkg::CS_LSB +: 3];
    assign enabled = ~power_reduction_register_q[tmr_pkg::PWR_TMR];
    assign pwm_mode = (waveform_mode_select == tmr_pkg::WGM_FAST_A) ||
                      (waveform_mode_select == tmr_pkg::WGM_FAST_CAP);
    assign cap_top  = (waveform_mode_select == tmr_pkg::WGM_FAST_CAP);

    ////////////////////////////////////////////////////////////////////////
    // clock select
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            presc_q <= 10'h000;
        end else begin
            presc_q <= presc_q + 10'h001;
        end
    end

    tmr_edge u_ext_edge (
        .CLK_I   (CLK_I),
        .RST_B_I (RST_B_I),
        .sig_i   (EXT_COUNT_PIN_I),
        .rise_i  (csel == tmr_pkg::CS_EXTR),
        .edge_o  (ext_edge)
    );

    always_comb begin
        unique case (csel)
            tmr_pkg::CS_STOP:   timer_tick = 1'b0;
            tmr_pkg::CS_DIV1:   timer_tick = 1'b1;
            tmr_pkg::CS_DIV8:   timer_tick = (presc_q[2:0] == 3'h7);
            tmr_pkg::CS_DIV64:  timer_tick = (presc_q[5:0] == 6'h3F);
            tmr_pkg::CS_DIV256: timer_tick = (presc_q[7:0] == 8'hFF);
            tmr_pkg::CS_DIV1K:  timer_tick = (presc_q == 10'h3FF);
            tmr_pkg::CS_EXTF:   timer_tick = ext_edge;
            tmr_pkg::CS_EXTR:   timer_tick = ext_edge;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // counter
    // top select
    always_comb begin
        unique case (waveform_mode_select)
            tmr_pkg::WGM_CTC_A:    top = compare_value_a_q;
            tmr_pkg::WGM_FAST_A:   top = compare_value_a_q;
            tmr_pkg::WGM_FAST_CAP: top = capture_value_q;
            default:               top = tmr_pkg::CNT_MAX;
        endcase
    end

    assign at_top  = (timer_count_value_q == top);
    assign match_a = (timer_count_value_q == compare_value_a_q);
    assign match_b = (timer_count_value_q == compare_value_b_q);
    assign wr_cnt  = WR_I && (ADDR_I == tmr_pkg::ADDR_CNT_L);

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            timer_count_value_q <= tmr_pkg::CNT_BOTTOM;
        end else if (wr_cnt) begin
            timer_count_value_q <= {latch_q, WDATA_I};
        end else if (enabled && timer_tick) begin
            if (at_top) begin
                timer_count_value_q <= tmr_pkg::CNT_BOTTOM;
            end else begin
                timer_count_value_q <= timer_count_value_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= enabled && timer_tick && !wr_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // compare registers, double buffered in pwm modes
    // buffered top
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            cmpa_buf_q        <= 16'h0000;
            cmpb_buf_q        <= 16'h0000;
            compare_value_a_q <= 16'h0000;
            compare_value_b_q <= 16'h0000;
        end else begin
            if (WR_I && ADDR_I == tmr_pkg::ADDR_CMPA_L) begin
                cmpa_buf_q <= {latch_q, WDATA_I};
            end
            if (WR_I && ADDR_I == tmr_pkg::ADDR_CMPB_L) begin
                cmpb_buf_q <= {latch_q, WDATA_I};
            end
            if (!pwm_mode || (enabled && timer_tick && at_top)) begin
                compare_value_a_q <= cmpa_buf_q;
                compare_value_b_q <= cmpb_buf_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // input capture
    assign cap_raw = timer_control_a_q[tmr_pkg::CAP_SRC] ? COMPARATOR_I : CAPTURE_PIN_I;

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            cap_hist_q <= '0;
            cap_filt_q <= 1'b0;
        end else begin
            cap_hist_q <= {cap_hist_q[NCW-2:0], cap_raw};
            if (&cap_hist_q) begin
                cap_filt_q <= 1'b1;
            end else if (~|cap_hist_q) begin
                cap_filt_q <= 1'b0;
            end
        end
    end

    assign cap_sig = timer_control_b_q[tmr_pkg::CAP_NC] ? cap_filt_q : cap_raw;

    tmr_edge u_cap_edge (
        .CLK_I   (CLK_I),
        .RST_B_I (RST_B_I),
        .sig_i   (cap_sig),
        .rise_i  (timer_control_b_q[tmr_pkg::CAP_EDGE]),
        .edge_o  (cap_edge)
    );

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            capture_value_q <= 16'h0000;
        end else if (WR_I && ADDR_I == tmr_pkg::ADDR_CAP_L) begin
            capture_value_q <= {latch_q, WDATA_I};
        end else if (enabled && cap_edge && !cap_top) begin
            capture_value_q <= timer_count_value_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flags and masks, set wins over clear-by-one
    // overflow, compare and capture flags
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            timer_flag_register_q <= 4'h0;
        end else begin
            timer_flag_register_q <=
                (timer_flag_register_q & ~((WR_I && ADDR_I == tmr_pkg::ADDR_FLAG) ? WDATA_I[3:0] : 4'h0)) |
                {cap_edge && enabled && !cap_top,
                 tick_q && match_b,
                 tick_q && match_a,
                 tick_q && timer_count_value_q == tmr_pkg::CNT_BOTTOM};
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            IRQ_OVF_O  <= 1'b0;
            IRQ_CMPA_O <= 1'b0;
            IRQ_CMPB_O <= 1'b0;
            IRQ_CAP_O  <= 1'b0;
        end else begin
            IRQ_OVF_O  <= timer_flag_register_q[tmr_pkg::FLG_OVF] & timer_mask_register_q[tmr_pkg::FLG_OVF];
            IRQ_CMPA_O <= timer_flag_register_q[tmr_pkg::FLG_CMPA] & timer_mask_register_q[tmr_pkg::FLG_CMPA];
            IRQ_CMPB_O <= timer_flag_register_q[tmr_pkg::FLG_CMPB] & timer_mask_register_q[tmr_pkg::FLG_CMPB];
            IRQ_CAP_O  <= timer_flag_register_q[tmr_pkg::FLG_CAP] & timer_mask_register_q[tmr_pkg::FLG_CAP];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // waveform outputs
    // waveform drive
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            COMPARE_OUTPUT_A_O <= 1'b0;
            COMPARE_OUTPUT_B_O <= 1'b0;
        end else if (pwm_mode) begin
            // no pwm on A when A is top
            COMPARE_OUTPUT_A_O <= cap_top ? (timer_count_value_q < compare_value_a_q) : 1'b0;
            COMPARE_OUTPUT_B_O <= (timer_count_value_q < compare_value_b_q);
        end else begin
            if (tick_q && match_a) begin
                COMPARE_OUTPUT_A_O <= ~COMPARE_OUTPUT_A_O;
            end
            if (tick_q && match_b) begin
                COMPARE_OUTPUT_B_O <= ~COMPARE_OUTPUT_B_O;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers and shared high-byte latch
    // plain control
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            timer_control_a_q          <= 8'h00;
            timer_control_b_q          <= 8'h00;
            timer_mask_register_q      <= 4'h0;
            power_reduction_register_q <= tmr_pkg::RST_POWER;
        end else if (WR_I) begin
            unique case (ADDR_I)
                tmr_pkg::ADDR_CTRL_A: timer_control_a_q <= WDATA_I;
                tmr_pkg::ADDR_CTRL_B: timer_control_b_q <= WDATA_I;
                tmr_pkg::ADDR_MASK:   timer_mask_register_q <= WDATA_I[3:0];
                tmr_pkg::ADDR_POWER:  power_reduction_register_q <= WDATA_I;
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            latch_q <= 8'h00;
        end else if (WR_I && (ADDR_I == tmr_pkg::ADDR_CNT_H || ADDR_I == tmr_pkg::ADDR_CMPA_H ||
                              ADDR_I == tmr_pkg::ADDR_CMPB_H || ADDR_I == tmr_pkg::ADDR_CAP_H)) begin
            latch_q <= WDATA_I;
        end else if (RD_I && ADDR_I == tmr_pkg::ADDR_CNT_L) begin
            latch_q <= timer_count_value_q[15:8];
        end else if (RD_I && ADDR_I == tmr_pkg::ADDR_CAP_L) begin
            latch_q <= capture_value_q[15:8];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, one cycle after the strobe
    // byte views
    always_comb begin
        unique case (ADDR_I)
            tmr_pkg::ADDR_CNT_L:  rdata_d = timer_count_value_q[7:0];
            tmr_pkg::ADDR_CNT_H:  rdata_d = latch_q;
            tmr_pkg::ADDR_CMPA_L: rdata_d = cmpa_buf_q[7:0];
            tmr_pkg::ADDR_CMPA_H: rdata_d = cmpa_buf_q[15:8];
            tmr_pkg::ADDR_CMPB_L: rdata_d = cmpb_buf_q[7:0];
            tmr_pkg::ADDR_CMPB_H: rdata_d = cmpb_buf_q[15:8];
            tmr_pkg::ADDR_CAP_L:  rdata_d = capture_value_q[7:0];
            tmr_pkg::ADDR_CAP_H:  rdata_d = latch_q;
            tmr_pkg::ADDR_CTRL_A: rdata_d = timer_control_a_q;
            tmr_pkg::ADDR_CTRL_B: rdata_d = timer_control_b_q;
            tmr_pkg::ADDR_FLAG:   rdata_d = {4'h0, timer_flag_register_q};
            tmr_pkg::ADDR_MASK:   rdata_d = {4'h0, timer_mask_register_q};
            tmr_pkg::ADDR_POWER:  rdata_d = power_reduction_register_q;
            default:              rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            RDATA_O <= 8'h00;
        end else if (RD_I) begin
            RDATA_O <= rdata_d;
        end else begin
            RDATA_O <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_hi_write;
        WR_I && ADDR_I == tmr_pkg::ADDR_CNT_H;
    endsequence

    sequence s_lo_write;
        WR_I && ADDR_I == tmr_pkg::ADDR_CNT_L;
    endsequence

    property p_power_off;
        @(posedge CLK_I) disable iff (!RST_B_I)
        (!enabled && !wr_cnt) |=> $stable(timer_count_value_q);
    endproperty
    a_power_off: assert property (p_power_off) else $error("counter moved while powered off");

    property p_stop;
        @(posedge CLK_I) disable iff (!RST_B_I)
        (csel == tmr_pkg::CS_STOP && !wr_cnt) |=> $stable(timer_count_value_q);
    endproperty
    a_stop: assert property (p_stop) else $error("counter moved with no clock source");

    property p_direct_count;
        @(posedge CLK_I) disable iff (!RST_B_I)
        (enabled && csel == tmr_pkg::CS_DIV1 && !wr_cnt && !at_top)
            |=> timer_count_value_q == $past(timer_count_value_q) + 16'h0001;
    endproperty
    a_direct_count: assert property (p_direct_count) else $error("direct clock did not count");

    property p_atomic_write;
        @(posedge CLK_I) disable iff (!RST_B_I)
        s_hi_write ##1 s_lo_write |=> timer_count_value_q == {$past(WDATA_I, 2), $past(WDATA_I)};
    endproperty
    a_atomic_write: assert property (p_atomic_write) else $error("16-bit write not assembled");

    property p_hi_only_latch;
        @(posedge CLK_I) disable iff (!RST_B_I)
        s_hi_write ##0 (!enabled || csel == tmr_pkg::CS_STOP) |=> $stable(timer_count_value_q);
    endproperty
    a_hi_only_latch: assert property (p_hi_only_latch) else $error("high write changed counter");

    property p_read_latch;
        @(posedge CLK_I) disable iff (!RST_B_I)
        (RD_I && ADDR_I == tmr_pkg::ADDR_CNT_L) ##1 (RD_I && ADDR_I == tmr_pkg::ADDR_CNT_H)
            |=> RDATA_O == $past(timer_count_value_q[15:8], 2);
    endproperty
    a_read_latch: assert property (p_read_latch) else $error("high read not from latch");

    property p_cmp_read;
        @(posedge CLK_I) disable iff (!RST_B_I)
        (RD_I && ADDR_I == tmr_pkg::ADDR_CMPA_H) |=> RDATA_O == $past(cmpa_buf_q[15:8]) && $stable(latch_q);
    endproperty
    a_cmp_read: assert property (p_cmp_read) else $error("compare read used latch");

    property p_cmpa_flag;
        @(posedge CLK_I) disable iff (!RST_B_I)
        (tick_q && match_a) |=> timer_flag_register_q[tmr_pkg::FLG_CMPA];
    endproperty
    a_cmpa_flag: assert property (p_cmpa_flag) else $error("compare A flag not set");

    property p_mask;
        @(posedge CLK_I) disable iff (!RST_B_I)
        !timer_mask_register_q[tmr_pkg::FLG_OVF] |=> !IRQ_OVF_O;
    endproperty
    a_mask: assert property (p_mask) else $error("masked request reached output");
endmodule : tmr_core

// ==== tmr_cpu_model.sv ====
`timescale 1ns/1ps
module tmr_cpu_model (
    // clock
    input  wire logic       clk_i,
    // register port
    output logic      [3:0] addr_o,
    output logic      [7:0] wdata_o,
    output logic            wr_o,
    output logic            rd_o,
    input  wire logic [7:0] rdata_i
);
    initial begin
        addr_o  = 4'h0;
        wdata_o = 8'h00;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // one-cycle write; released lines show the inverse of the last value
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        addr_o  <= ~a;
        wdata_o <= ~d;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge clk_i);
        rd_o   <= 1'b0;
        addr_o <= ~a;
        #1 d = rdata_i;
    endtask : rd
    ////////////////////////////////////////////////////////////////
    // ordered, uninterrupted pairs
    // the two bytes go back to back, strobe held high across both
    task automatic wr16(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk_i);
        addr_o  <= a + 4'h1;
        wdata_o <= v[15:8];
        wr_o    <= 1'b1;
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= v[7:0];
        @(posedge clk_i);
        wr_o    <= 1'b0;
        addr_o  <= ~a;
        wdata_o <= ~v[7:0];
    endtask : wr16
    task automatic rd16(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge clk_i);
        addr_o <= a + 4'h1;
        #1 v[7:0] = rdata_i;
        @(posedge clk_i);
        rd_o   <= 1'b0;
        addr_o <= ~a;
        #1 v[15:8] = rdata_i;
    endtask : rd16
endmodule : tmr_cpu_model

// ==== tb_top.sv ====
`timescale 1ns/1ps
`define CHK(a, e, m) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; $display("wrong value at %0t: %s", $time, m); end end
module tb_top;
    logic        clk;
    logic        rst_b;
    logic [3:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic        ext_pin;
    logic        cap_pin;
    logic        cmp_in;
    logic        out_a;
    logic        out_b;
    logic [3:0]  irq;
    int          n_mismatch;
    int          tests_run;
    int          k;
    logic [7:0]  m_latch;
    logic [15:0] v;
    logic [15:0] x;
    logic [7:0]  y;
    logic [1:0]  ob;

    tmr_core dut_u (.CLK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .EXT_COUNT_PIN_I(ext_pin), .CAPTURE_PIN_I(cap_pin), .COMPARATOR_I(cmp_in),
        .COMPARE_OUTPUT_A_O(out_a), .COMPARE_OUTPUT_B_O(out_b), .IRQ_OVF_O(irq[0]), .IRQ_CMPA_O(irq[1]),
        .IRQ_CMPB_O(irq[2]), .IRQ_CAP_O(irq[3]));
    tmr_cpu_model cpu_u (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata));

    ////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    task automatic chk8(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] d;
        cpu_u.rd(a, d);
        `CHK(d, e, "register byte")
    endtask : chk8
    task automatic chk16(input logic [3:0] a, input logic [15:0] e);
        logic [15:0] d;
        cpu_u.rd16(a, d);
        `CHK(d, e, "register word")
    endtask : chk16
    task automatic set_cs(input logic [2:0] c);
        cpu_u.wr(tmr_pkg::ADDR_CTRL_B, {5'h00, c});
    endtask : set_cs
    task automatic cap_try(input logic src, input logic rise);
        @(posedge clk);
        cap_pin <= ~rise;
        cmp_in  <= ~rise;
        cpu_u.wr(tmr_pkg::ADDR_CTRL_A, {5'h00, src, 2'h0});
        cpu_u.wr(tmr_pkg::ADDR_CTRL_B, {1'b0, rise, 6'h00});
        v = 16'($urandom);
        cpu_u.wr16(tmr_pkg::ADDR_CNT_L, v);
        cpu_u.wr(tmr_pkg::ADDR_FLAG, 8'h0F);
        @(posedge clk);
        if (src) cmp_in <= rise;
        else cap_pin <= rise;
        repeat (8) @(posedge clk);
        chk16(tmr_pkg::ADDR_CAP_L, v);
        chk8(tmr_pkg::ADDR_FLAG, 8'h08);
    endtask : cap_try

    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        rst_b   = 1'b0;
        ext_pin = 1'b0;
        cap_pin = 1'b0;
        cmp_in  = 1'b0;
        void'($urandom(32'h465b1b78));
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1 `CHK({rdata, out_a, out_b, irq}, 14'h0000, "reset outputs")
        chk8(tmr_pkg::ADDR_POWER, tmr_pkg::RST_POWER);
        chk16(tmr_pkg::ADDR_CNT_L, tmr_pkg::CNT_BOTTOM);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            v = 16'($urandom);
            cpu_u.wr16(tmr_pkg::ADDR_CNT_L, v);
            chk16(tmr_pkg::ADDR_CNT_L, v);
            cpu_u.wr(tmr_pkg::ADDR_CNT_H, ~v[15:8]);
            chk16(tmr_pkg::ADDR_CNT_L, v);
        end
        x = 16'($urandom);
        cpu_u.wr16(tmr_pkg::ADDR_CMPA_L, x);
        y = 8'($urandom);
        cpu_u.wr(tmr_pkg::ADDR_CNT_H, y);
        m_latch = y;
        chk16(tmr_pkg::ADDR_CMPA_L, x);
        y = 8'($urandom);
        cpu_u.wr(tmr_pkg::ADDR_CMPB_L, y);
        chk16(tmr_pkg::ADDR_CMPB_L, {m_latch, y});
        cpu_u.wr(tmr_pkg::ADDR_CNT_L, y);
        chk16(tmr_pkg::ADDR_CNT_L, {m_latch, y});
        y = 8'($urandom) & 8'h07;
        cpu_u.wr(tmr_pkg::ADDR_CTRL_A, y);
        chk8(tmr_pkg::ADDR_CTRL_A, y);
        y = 8'($urandom) & 8'hD8;
        cpu_u.wr(tmr_pkg::ADDR_CTRL_B, y);
        chk8(tmr_pkg::ADDR_CTRL_B, y);
        cpu_u.wr(tmr_pkg::ADDR_CTRL_A, 8'h00);
        cpu_u.wr(tmr_pkg::ADDR_CTRL_B, 8'h00);
        $display("test byte access done");
        v = 16'h1000;
        cpu_u.wr16(tmr_pkg::ADDR_CNT_L, v);
        repeat (20) @(posedge clk);
        chk16(tmr_pkg::ADDR_CNT_L, v);
        cpu_u.wr(tmr_pkg::ADDR_POWER, 8'h01);
        set_cs(tmr_pkg::CS_DIV1);
        repeat (30) @(posedge clk);
        set_cs(tmr_pkg::CS_STOP);
        chk16(tmr_pkg::ADDR_CNT_L, v);
        cpu_u.wr(tmr_pkg::ADDR_POWER, 8'h00);
        set_cs(tmr_pkg::CS_DIV1);
        repeat (100) @(posedge clk);
        set_cs(tmr_pkg::CS_STOP);
        cpu_u.rd16(tmr_pkg::ADDR_CNT_L, x);
        `CHK((x - v) >= 16'd100 && (x - v) <= 16'd104, 1'b1, "direct count")
        set_cs(tmr_pkg::CS_DIV8);
        repeat (800) @(posedge clk);
        set_cs(tmr_pkg::CS_STOP);
        cpu_u.rd16(tmr_pkg::ADDR_CNT_L, v);
        `CHK((v - x) >= 16'd99 && (v - x) <= 16'd101, 1'b1, "prescaled count")
        for (int i = 0; i < 2; i++) begin
            k = 2 + $urandom % 4;
            cpu_u.wr16(tmr_pkg::ADDR_CNT_L, 16'h0000);
            set_cs(i ? tmr_pkg::CS_EXTF : tmr_pkg::CS_EXTR);
            for (int j = 0; j <= 2 * k; j++) begin
                repeat (6) @(posedge clk);
                ext_pin <= ~ext_pin;
            end
            repeat (8) @(posedge clk);
            set_cs(tmr_pkg::CS_STOP);
            @(posedge clk);
            ext_pin <= 1'b0;
            chk16(tmr_pkg::ADDR_CNT_L, 16'(i ? k : k + 1));
        end
        $display("test clocking done");
        cpu_u.wr16(tmr_pkg::ADDR_CNT_L, 16'h0000);
        cpu_u.wr16(tmr_pkg::ADDR_CMPA_L, 16'd30);
        cpu_u.wr16(tmr_pkg::ADDR_CMPB_L, 16'd50);
        cpu_u.wr(tmr_pkg::ADDR_FLAG, 8'h0F);
        ob = {out_b, out_a};
        set_cs(tmr_pkg::CS_DIV1);
        repeat (80) @(posedge clk);
        set_cs(tmr_pkg::CS_STOP);
        chk8(tmr_pkg::ADDR_FLAG, 8'h06);
        `CHK({out_b, out_a, irq}, {~ob, 4'h0}, "compare outputs")
        cpu_u.wr(tmr_pkg::ADDR_MASK, 8'h02);
        repeat (3) @(posedge clk);
        `CHK(irq, 4'h2, "masked request")
        cpu_u.wr(tmr_pkg::ADDR_FLAG, 8'h02);
        repeat (3) @(posedge clk);
        `CHK(irq, 4'h0, "cleared request")
        chk8(tmr_pkg::ADDR_FLAG, 8'h04);
        cpu_u.wr(tmr_pkg::ADDR_MASK, 8'h00);
        // clear on compare A: 82 ticks with top 30 wrap twice and end at 20
        cpu_u.wr(tmr_pkg::ADDR_MASK, 8'h01);
        cpu_u.wr16(tmr_pkg::ADDR_CNT_L, 16'h0000);
        cpu_u.wr(tmr_pkg::ADDR_FLAG, 8'h0F);
        cpu_u.wr(tmr_pkg::ADDR_CTRL_B, {3'h0, tmr_pkg::WGM_CTC_A[3:2], tmr_pkg::CS_DIV1});
        repeat (80) @(posedge clk);
        set_cs(tmr_pkg::CS_STOP);
        chk16(tmr_pkg::ADDR_CNT_L, 16'd20);
        chk8(tmr_pkg::ADDR_FLAG, 8'h03);
        `CHK(irq, 4'h1, "overflow request")
        cpu_u.wr(tmr_pkg::ADDR_MASK, 8'h00);
        $display("test compare done");
        for (int i = 0; i < 4; i++) cap_try(i[0], i[1]);
        for (int i = 13; i < 16; i++) chk8(4'(i), 8'h00);
        $display("test capture done");
        tally_and_finish();
    end
endmodule : tb_top
